// ### bench/sps_far_model.sv
/* Far-side model: rail and thermal monitors answering the enables.
   Assumes the bench sets mains and temperature levels. */
`timescale 1ns/1ps
module sps_far_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// bench controls
	input wire logic mains_ok,
	input wire logic [1:0] temp,
	// device side
	input wire sps_pkg::sps_supply_s supply_en,
	output sps_pkg::sps_monitor_s monitor
);
	import sps_pkg::*;
	sps_supply_s d1, d2, d3;
	logic [5:0] ok;
	// rails settle slowly but read bad as soon as disabled
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			d1 <= '0;
			d2 <= '0;
			d3 <= '0;
		end else begin
			d1 <= supply_en;
			d2 <= d1 & supply_en;
			d3 <= d2 & supply_en;
		end
	end
	assign ok = d3 & supply_en;
	// each rail answers its own enable; temp[0] is the warning, temp[1] the
	// error, so the bench can raise either one alone
	assign monitor = {mains_ok, mains_ok, ok[5], ok[4], ok[3], ok[2], ok[0],
		ok[1], temp[0], temp[1]};
endmodule : sps_far_model

// ### bench/sps_top_sva.sv
/* Port assertions for sps_top.
   Assumes binding to sps_top; level pins pass two sync stages. */
`timescale 1ns/1ps
module sps_top_sva (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// pins
	input wire logic system_on_request,
	input wire sps_pkg::sps_monitor_s monitor,
	input wire sps_pkg::sps_supply_s supply_en,
	input wire logic host_reset_out,
	input wire logic mirror_park_out,
	// register ports
	input wire logic main_rd,
	input wire logic [15:0] main_rdata,
	input wire logic mon_rd,
	input wire logic [7:0] mon_addr,
	input wire logic [15:0] mon_rdata
);
	import sps_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// four cycles cover the sync stages plus the register
	sequence s_low_read;
		!system_on_request [*4] ##0 (mon_rd && mon_addr == ADDR_EVENT_STATUS);
	endsequence
	sequence s_err_held;
		monitor.temp_err [*5];
	endsequence
	a_reset_all_off: assert property (
		$fell(rst) |-> supply_en == '0 && !host_reset_out)
		else $error("outputs active after reset");
	a_order_mid: assert property (
		$rose(supply_en.en_1p8) |-> supply_en.en_1p1)
		else $error("1.8 V enabled before 1.1 V");
	a_order_last: assert property (
		$rose(supply_en.en_3p3) |-> supply_en.en_1p1 && supply_en.en_1p8)
		else $error("3.3 V enabled out of order");
	a_release_powered: assert property (
		$rose(host_reset_out) |-> supply_en[5:3] == 3'b111)
		else $error("host reset released before supplies");
	a_park_on_err: assert property (
		s_err_held |-> !mirror_park_out)
		else $error("park not driven on over-temperature");
	a_low_flag: assert property (
		s_low_read |=> mon_rdata[EV_ON_REQ_LOW])
		else $error("request-low flag missing");
	a_revision_read: assert property (
		mon_rd && mon_addr == ADDR_CHIP_REVISION
		|=> mon_rdata == {8'h00, REV_MAJOR, REV_MINOR})
		else $error("revision read wrong");
	a_rdata_holds: assert property (
		!main_rd |=> $stable(main_rdata))
		else $error("read data changed without a read");
endmodule : sps_top_sva

// ### bench/tb_sps_top.sv
/* Bench for sps_top: register reads and writes, command pulses.
   Assumes the far-side model answers the supply enables. */
`timescale 1ns/1ps
module tb_sps_top;
	import sps_pkg::*;
	localparam logic [7:0] GS = ADDR_GENERAL_STATUS_ONE;
	localparam logic [7:0] EV = ADDR_EVENT_STATUS;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic req = 1'b0;
	logic mains_ok = 1'b0;
	logic [1:0] temp = 2'b00;
	logic [15:0] conv = 16'h0000;
	sps_command_s cmd = '0;
	logic main_rd = 1'b0;
	logic main_wr = 1'b0;
	logic [7:0] main_addr = 8'h00;
	logic [15:0] main_wdata = 16'h0000;
	logic mon_rd = 1'b0;
	logic [7:0] mon_addr = 8'h00;
	logic [15:0] main_rdata, mon_rdata;
	sps_monitor_s monitor;
	sps_supply_s supply_en;
	logic host_reset_out, mirror_park_out;
	int n_fail = 0;
	int comparisons = 0;
	int cycles = 0;
	sps_command_s c;
	sps_cause_e cz [3] = '{CAUSE_SW_CYCLE, CAUSE_WD_ONE, CAUSE_WD_TWO};

	sps_top #(.RESET_HOLD_CYC(4), .PARK_CYC(4)) sps_top_i (
		.clk(clk), .rst(rst), .system_on_request(req), .monitor(monitor),
		.converter_errors(conv), .command(cmd), .supply_en(supply_en),
		.host_reset_out(host_reset_out), .mirror_park_out(mirror_park_out),
		.main_rd(main_rd), .main_wr(main_wr), .main_addr(main_addr),
		.main_wdata(main_wdata), .main_rdata(main_rdata), .mon_rd(mon_rd),
		.mon_addr(mon_addr), .mon_rdata(mon_rdata));
	sps_far_model sps_far_model_i (.clk(clk), .rst(rst), .mains_ok(mains_ok),
		.temp(temp), .supply_en(supply_en), .monitor(monitor));

	task automatic complete_run;
		$display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	// strobes drop with an idle edge after, so no signal is set twice at once
	task automatic idle;
		@(posedge clk);
		#1;
	endtask : idle

	task automatic rd(input bit m, input logic [7:0] a,
			input logic [15:0] k, input logic [15:0] e);
		main_rd = m;
		main_addr = a;
		mon_rd = !m;
		mon_addr = a;
		idle();
		main_rd = 1'b0;
		mon_rd = 1'b0;
		idle();
		check((m ? main_rdata : mon_rdata) & k, e);
	endtask : rd

	task automatic clr(input logic [15:0] w);
		main_wr = 1'b1;
		main_addr = EV;
		main_wdata = w;
		idle();
		main_wr = 1'b0;
		idle();
	endtask : clr

	task automatic pulse(input sps_command_s p);
		cmd = p;
		idle();
		cmd = '0;
		idle();
	endtask : pulse

	task automatic wait_state(input sps_state_e s);
		int n;
		n = 0;
		mon_addr = GS;
		mon_rd = 1'b1;
		do begin
			idle();
			n++;
		end while (mon_rdata[4:0] !== s && n < 300);
		mon_rd = 1'b0;
		idle();
		check({11'h000, mon_rdata[4:0]}, {11'h000, s});
	endtask : wait_state

	initial begin
		forever #20 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 8000) begin
			n_fail++;
			complete_run();
		end
	end

	initial begin
		repeat (12) @(posedge clk);
		#1;
		rst = 1'b0;
		rd(0, ADDR_CHIP_REVISION, 16'hFFFF, {8'h00, REV_MAJOR, REV_MINOR});
		check({9'h000, host_reset_out, supply_en}, 16'h0000);
		rd(1, GS, 16'hFFFF, {8'h00, CAUSE_POR, ST_OFF});
		// mirror rail faults count only while their regulator is enabled
		rd(0, ADDR_SUPPLY_FAULT, 16'hF407, 16'h1407);
		rd(0, EV, 16'h8001, 16'h8001);
		conv = 16'h0010;
		idle();
		conv = 16'h0000;
		c = '0;
		c.main_parity_err = 1'b1;
		c.mirror_pg_init_err = 1'b1;
		pulse(c);
		rd(1, EV, 16'h3800, 16'h3800);
		clr(16'hFFFF);
		rd(1, EV, 16'h3800, 16'h0000);
		// warning alone must hold the device in OFF
		temp = 2'b01;
		mains_ok = 1'b1;
		req = 1'b1;
		repeat (10) idle();
		rd(1, GS, 16'h001F, {11'h000, ST_OFF});
		rd(1, EV, 16'h0004, 16'h0004);
		temp = 2'b00;
		wait_state(ST_STANDBY);
		check({9'h000, host_reset_out, supply_en}, 16'h0078);
		rd(0, EV, 16'h0020, 16'h0020);
		// request drops mid power-up: sequence completes, then parks
		pulse('{mirror_enable_begin: 1'b1, default: 1'b0});
		wait_state(ST_MIRROR_POWER_UP);
		req = 1'b0;
		repeat (8) idle();
		rd(1, GS, 16'h001F, {11'h000, ST_MIRROR_POWER_UP});
		pulse('{mirror_confirmed: 1'b1, default: 1'b0});
		wait_state(ST_PARK_START);
		check({15'h0000, mirror_park_out}, 16'h0000);
		wait_state(ST_OFF);
		rd(1, GS, 16'h00FF, {8'h00, CAUSE_ON_LOW, ST_OFF});
		req = 1'b1;
		wait_state(ST_STANDBY);
		pulse('{mirror_enable_begin: 1'b1, default: 1'b0});
		pulse('{mirror_confirmed: 1'b1, default: 1'b0});
		wait_state(ST_DISPLAY_READY);
		pulse('{illumination_on: 1'b1, default: 1'b0});
		wait_state(ST_DISPLAY_ON);
		check({10'h000, supply_en}, 16'h003F);
		pulse('{park_cmd: 1'b1, default: 1'b0});
		wait_state(ST_PARK_START);
		check({15'h0000, mirror_park_out}, 16'h0000);
		wait_state(ST_STANDBY);
		check({15'h0000, mirror_park_out}, 16'h0001);
		check({10'h000, supply_en}, 16'h0038);
		// power cycle, then each watchdog; cause shows the pass through OFF
		for (int i = 0; i < 3; i++) begin
			c = '0;
			c[4 - i] = 1'b1;
			pulse(c);
			wait_state(ST_STANDBY);
			rd(0, GS, 16'h00FF, {8'h00, cz[i], ST_STANDBY});
		end
		rd(1, EV, 16'h00C0, 16'h00C0);
		temp = 2'b10;
		wait_state(ST_SHUTDOWN);
		check({10'h000, supply_en}, 16'h0000);
		rd(1, EV, 16'h0002, 16'h0002);
		temp = 2'b00;
		req = 1'b0;
		wait_state(ST_OFF);
		rd(1, GS, 16'h00FF, {8'h00, CAUSE_OVER_TEMP, ST_OFF});
		complete_run();
	end
endmodule : tb_sps_top

bind sps_top sps_top_sva sps_top_sva_i (.clk(clk), .rst(rst),
	.system_on_request(system_on_request), .monitor(monitor),
	.supply_en(supply_en), .host_reset_out(host_reset_out),
	.mirror_park_out(mirror_park_out), .main_rd(main_rd),
	.main_rdata(main_rdata), .mon_rd(mon_rd), .mon_addr(mon_addr),
	.mon_rdata(mon_rdata));

// ### verilog/sps_pkg.sv
/*
 * Constants, state codes and carrier structs for the system power state
 * machine. Assumes a single 25 MHz clock domain.
 */
package sps_pkg;
	// register offsets (word index on the register port)
	localparam logic [7:0] ADDR_CHIP_REVISION = 8'h00;
	localparam logic [7:0] ADDR_EVENT_STATUS = 8'h01;
	localparam logic [7:0] ADDR_GENERAL_STATUS_ONE = 8'h05;
	localparam logic [7:0] ADDR_CONVERTER_ERROR = 8'h0D;
	localparam logic [7:0] ADDR_SUPPLY_FAULT = 8'h38;
	// event status bit positions
	localparam int EV_SUPPLY_FAULT = 15;
	localparam int EV_MIRROR_PG_INIT = 13;
	localparam int EV_MAIN_PARITY = 12;
	localparam int EV_CONVERTER = 11;
	localparam int EV_WATCHDOG_TWO = 7;
	localparam int EV_WATCHDOG_ONE = 6;
	localparam int EV_STATE_CHANGE = 5;
	localparam int EV_MIRROR_PG_FAULT = 3;
	localparam int EV_TEMP_WARN = 2;
	localparam int EV_TEMP_ERR = 1;
	localparam int EV_ON_REQ_LOW = 0;
	// general status one fields
	localparam int GS_CAUSE_LSB = 5;
	localparam int GS_STATE_LSB = 0;
	// supply fault fields
	localparam int SF_BIAS = 15;
	localparam int SF_RESET = 14;
	localparam int SF_OFFSET = 13;
	localparam int SF_MAIN = 12;
	localparam int SF_CORE_OR = 10;
	localparam int SF_3P3 = 2;
	localparam int SF_1P8 = 1;
	localparam int SF_1P1 = 0;
	// reset values
	localparam logic [15:0] EVENT_STATUS_RESET = 16'h0000;
	localparam logic [3:0] REV_MAJOR = 4'h1; // arbitrary value
	localparam logic [3:0] REV_MINOR = 4'h0; // arbitrary value
	// timing
	localparam int CLK_HZ = 25000000;
	localparam int HOST_RESET_HOLD_US = 100;
	localparam int HOST_RESET_HOLD_CYC = HOST_RESET_HOLD_US * (CLK_HZ / 1000000);
	localparam int PARK_STEP_US = 100;
	localparam int PARK_STEP_CYC = PARK_STEP_US * (CLK_HZ / 1000000);

	typedef enum logic [2:0] {
		CAUSE_POR = 3'b000,
		CAUSE_ON_LOW = 3'b001,
		CAUSE_WD_ONE = 3'b010,
		CAUSE_WD_TWO = 3'b011,
		CAUSE_OVER_TEMP = 3'b100,
		CAUSE_SW_CYCLE = 3'b101
	} sps_cause_e;

	typedef enum logic [4:0] {
		ST_SHUTDOWN = 5'h00,
		ST_OFF = 5'h02,
		ST_INIT_1P1 = 5'h04,
		ST_INIT_1P8 = 5'h05,
		ST_INIT_3P3 = 5'h06,
		ST_RELEASE_RESET = 5'h07,
		ST_STANDBY = 5'h08,
		ST_MIRROR_POWER_UP = 5'h09,
		ST_DISPLAY_READY = 5'h0C,
		ST_DISPLAY_ON = 5'h0D,
		ST_PARK_START = 5'h0E,
		ST_PARK_BIAS_OFF = 5'h0F,
		ST_PARK_OFFSET_OFF = 5'h10,
		ST_DISCHARGE = 5'h11
	} sps_state_e;

	// analog monitor levels, 1 = good / in range; temp_warn and temp_err are 1 when raised
	typedef struct packed {
		logic main_input_supply;
		logic six_volt_input;
		logic rail_1p1;
		logic rail_1p8;
		logic rail_3p3;
		logic offset_rail;
		logic reset_rail;
		logic bias_rail;
		logic temp_warn;
		logic temp_err;
	} sps_monitor_s;

	// one-cycle commands and events from the controller side
	typedef struct packed {
		logic mirror_enable_begin;
		logic mirror_confirmed;
		logic illumination_on;
		logic park_cmd;
		logic power_cycle_cmd;
		logic watchdog_one_err;
		logic watchdog_two_err;
		logic main_parity_err;
		logic mirror_pg_init_err;
	} sps_command_s;

	typedef struct packed {
		logic en_1p1;
		logic en_1p8;
		logic en_3p3;
		logic en_offset;
		logic en_bias;
		logic en_reset;
	} sps_supply_s;
endpackage : sps_pkg

// ### verilog/sps_top.sv
/*
 * Top-level operating-state controller: supply sequencing, host reset,
 * mirror park and status registers on a simple word register port.
 * Assumes monitor levels and on-request arrive asynchronously (synchronised
 * here) and commands arrive as one-cycle pulses on clk.
 */
`timescale 1ns/1ps
module sps_top #(
	parameter int RESET_HOLD_CYC = sps_pkg::HOST_RESET_HOLD_CYC,
	parameter int PARK_CYC = sps_pkg::PARK_STEP_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// pins
	input wire logic system_on_request,
	input wire sps_pkg::sps_monitor_s monitor,
	input wire logic [15:0] converter_errors,
	input wire sps_pkg::sps_command_s command,
	output sps_pkg::sps_supply_s supply_en,
	output logic host_reset_out,
	output logic mirror_park_out,
	// main serial port register access
	input wire logic main_rd,
	input wire logic main_wr,
	input wire logic [7:0] main_addr,
	input wire logic [15:0] main_wdata,
	output logic [15:0] main_rdata,
	// monitor serial port, read only
	input wire logic mon_rd,
	input wire logic [7:0] mon_addr,
	output logic [15:0] mon_rdata
);
	import sps_pkg::*;

	localparam int CW = 24;

	// pin synchronisers
	logic [10:0] sync_a;
	logic [10:0] sync_b;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync_a <= 11'h000;
			sync_b <= 11'h000;
		end else begin
			sync_a <= {system_on_request, monitor};
			sync_b <= sync_a;
		end
	end
	logic on_req;
	sps_monitor_s mon;
	assign on_req = sync_b[10];
	assign mon = sync_b[9:0];

	logic core_good;
	logic power_good;
	logic temp_err;
	assign core_good = mon.rail_1p1 & mon.rail_1p8 & mon.rail_3p3 &
		mon.six_volt_input;
	assign power_good = core_good & mon.main_input_supply;
	assign temp_err = mon.temp_err;

	sps_state_e state;
	sps_state_e next_state;
	sps_cause_e cause;
	logic [CW-1:0] timer;
	logic timer_done;
	logic on_low_seen;
	assign timer_done = (timer == '0);

	logic park_event;
	assign park_event = ~power_good | ~on_req | temp_err |
		command.park_cmd | command.power_cycle_cmd;

	always_comb begin
		next_state = state;
		unique case (state)
			ST_SHUTDOWN: if (~on_req) next_state = ST_OFF;
			ST_OFF: if (mon.main_input_supply & on_req & ~mon.temp_warn)
				next_state = ST_INIT_1P1;
			ST_INIT_1P1: if (mon.rail_1p1) next_state = ST_INIT_1P8;
			ST_INIT_1P8: if (mon.rail_1p8) next_state = ST_INIT_3P3;
			ST_INIT_3P3: if (power_good) next_state = ST_RELEASE_RESET;
			ST_RELEASE_RESET: begin
				if (~power_good) next_state = ST_OFF;
				else if (timer_done) next_state = ST_STANDBY;
			end
			ST_STANDBY: begin
				if (temp_err) next_state = ST_SHUTDOWN;
				else if (~on_req | command.power_cycle_cmd |
					command.watchdog_one_err | command.watchdog_two_err |
					~power_good)
					next_state = ST_OFF;
				else if (command.mirror_enable_begin)
					next_state = ST_MIRROR_POWER_UP;
			end
			ST_MIRROR_POWER_UP: begin
				if (temp_err) next_state = ST_PARK_START;
				else if (command.mirror_confirmed)
					next_state = ST_DISPLAY_READY;
			end
			ST_DISPLAY_READY: begin
				if (park_event | on_low_seen) next_state = ST_PARK_START;
				else if (command.illumination_on)
					next_state = ST_DISPLAY_ON;
			end
			ST_DISPLAY_ON: if (park_event) next_state = ST_PARK_START;
			ST_PARK_START: if (timer_done) next_state = ST_PARK_BIAS_OFF;
			ST_PARK_BIAS_OFF: if (timer_done)
				next_state = ST_PARK_OFFSET_OFF;
			ST_PARK_OFFSET_OFF: if (timer_done) next_state = ST_DISCHARGE;
			ST_DISCHARGE: begin
				if (timer_done)
					next_state = temp_err ? ST_SHUTDOWN : ST_STANDBY;
			end
			default: next_state = ST_OFF;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) state <= ST_OFF;
		else state <= next_state;
	end

	// timer reloads on every state entry
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			timer <= '0;
		end else if (next_state != state) begin
			if (next_state == ST_RELEASE_RESET)
				timer <= CW'(RESET_HOLD_CYC - 1);
			else
				timer <= CW'(PARK_CYC - 1);
		end else if (!timer_done) begin
			timer <= timer - 1'b1;
		end
	end

	// request low during mirror power-up is remembered, acted on later
	always_ff @(posedge clk or posedge rst) begin
		if (rst) on_low_seen <= 1'b0;
		else if (state == ST_MIRROR_POWER_UP && !on_req)
			on_low_seen <= 1'b1;
		else if (state != ST_MIRROR_POWER_UP && state != ST_DISPLAY_READY)
			on_low_seen <= 1'b0;
	end

	// cause of the last pass through OFF, except a pass forced by lost power-good, which keeps the old cause
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cause <= CAUSE_POR;
		end else if (next_state == ST_OFF && state != ST_OFF) begin
			if (state == ST_SHUTDOWN) cause <= CAUSE_OVER_TEMP;
			else if (~on_req) cause <= CAUSE_ON_LOW;
			else if (command.watchdog_one_err) cause <= CAUSE_WD_ONE;
			else if (command.watchdog_two_err) cause <= CAUSE_WD_TWO;
			else if (command.power_cycle_cmd) cause <= CAUSE_SW_CYCLE;
		end
	end

	// supply enables, async off under reset
	logic core_on;
	logic mirror_on;
	assign core_on = (state != ST_OFF) && (state != ST_SHUTDOWN);
	assign mirror_on = (state == ST_MIRROR_POWER_UP) ||
		(state == ST_DISPLAY_READY) || (state == ST_DISPLAY_ON) ||
		(state == ST_PARK_START);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			supply_en <= '0;
			host_reset_out <= 1'b0;
			mirror_park_out <= 1'b1;
		end else begin
			supply_en.en_1p1 <= core_on;
			supply_en.en_1p8 <= core_on && state != ST_INIT_1P1;
			supply_en.en_3p3 <= core_on && state != ST_INIT_1P1 &&
				state != ST_INIT_1P8;
			supply_en.en_offset <= mirror_on || state == ST_PARK_BIAS_OFF;
			supply_en.en_bias <= mirror_on;
			supply_en.en_reset <= mirror_on;
			host_reset_out <= core_on && state != ST_INIT_1P1 &&
				state != ST_INIT_1P8 && state != ST_INIT_3P3 &&
				state != ST_RELEASE_RESET;
			// temperature error forces park regardless of software
			mirror_park_out <= !((state >= ST_PARK_START) || temp_err);
		end
	end

	// supply fault register, live
	logic [15:0] supply_fault;
	always_comb begin
		supply_fault = 16'h0000;
		supply_fault[SF_BIAS] = ~mon.bias_rail & ~supply_en.en_bias ? 1'b0
			: ~mon.bias_rail;
		supply_fault[SF_RESET] = ~mon.reset_rail & supply_en.en_reset;
		supply_fault[SF_OFFSET] = ~mon.offset_rail & supply_en.en_offset;
		supply_fault[SF_MAIN] = ~mon.main_input_supply;
		supply_fault[SF_CORE_OR] = ~core_good;
		supply_fault[SF_3P3] = ~mon.rail_3p3;
		supply_fault[SF_1P8] = ~mon.rail_1p8;
		supply_fault[SF_1P1] = ~mon.rail_1p1;
	end

	// event status: hardware set wins over software clear (write 1 clears)
	logic [15:0] event_flags;
	logic [15:0] ev_set;
	logic [15:0] ev_clr;
	always_comb begin
		ev_set = 16'h0000;
		ev_set[EV_SUPPLY_FAULT] = |supply_fault;
		ev_set[EV_MIRROR_PG_INIT] = command.mirror_pg_init_err;
		ev_set[EV_MAIN_PARITY] = command.main_parity_err;
		ev_set[EV_CONVERTER] = |converter_errors;
		ev_set[EV_WATCHDOG_TWO] = command.watchdog_two_err;
		ev_set[EV_WATCHDOG_ONE] = command.watchdog_one_err;
		ev_set[EV_STATE_CHANGE] = (next_state != state);
		ev_set[EV_MIRROR_PG_FAULT] = supply_fault[SF_RESET] |
			supply_fault[SF_OFFSET];
		ev_set[EV_TEMP_WARN] = mon.temp_warn;
		ev_set[EV_TEMP_ERR] = temp_err;
		ev_clr = (main_wr && main_addr == ADDR_EVENT_STATUS) ?
			main_wdata : 16'h0000;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) event_flags <= EVENT_STATUS_RESET;
		else event_flags <= (event_flags & ~ev_clr) | ev_set;
	end

	logic [15:0] event_view;
	logic [15:0] status_one;
	assign event_view = {event_flags[15:1], ~on_req};
	assign status_one = {8'h00, cause, state};

	function automatic logic [15:0] reg_read(input logic [7:0] a,
		input logic [15:0] ev, input logic [15:0] st,
		input logic [15:0] cv, input logic [15:0] sf);
		unique case (a)
			ADDR_CHIP_REVISION: reg_read = {8'h00, REV_MAJOR, REV_MINOR};
			ADDR_EVENT_STATUS: reg_read = ev;
			ADDR_GENERAL_STATUS_ONE: reg_read = st;
			ADDR_CONVERTER_ERROR: reg_read = cv;
			ADDR_SUPPLY_FAULT: reg_read = sf;
			default: reg_read = 16'h0000;
		endcase
	endfunction : reg_read

	// read data registered one cycle after the strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			main_rdata <= 16'h0000;
			mon_rdata <= 16'h0000;
		end else begin
			if (main_rd)
				main_rdata <= reg_read(main_addr, event_view, status_one,
					converter_errors, supply_fault);
			if (mon_rd)
				mon_rdata <= reg_read(mon_addr, event_view, status_one,
					converter_errors, supply_fault);
		end
	end
	// single clock domain throughout
endmodule : sps_top
